// [src/dms_defines.svh]
// constants for the dds mode and tone select block
`ifndef DMS_DEFINES_SVH
`define DMS_DEFINES_SVH
`define DMS_ADDR_W        6
`define DMS_ADDR_FIRST_TUNING_WORD_LO  6'h04
`define DMS_ADDR_FIRST_TUNING_WORD_HI  6'h09
`define DMS_ADDR_SECOND_TUNING_WORD_LO  6'h0a
`define DMS_ADDR_SECOND_TUNING_WORD_HI  6'h0f
`define DMS_ADDR_PHASE_HI 6'h00
`define DMS_ADDR_PHASE_LO 6'h01
`define DMS_QUARTER       14'h1000
`define DMS_ADDR_CTRL     6'h1f
`define DMS_FTW_W         48
`define DMS_PHASE_W       14
`define DMS_DAC_W         12
`define DMS_FTW_RST       48'h0
`define DMS_CTRL_RST      8'h00
`define DMS_MODE_LSB      1
`define DMS_DAC_MID       12'h800
`define DMS_PIPE_DEPTH    4
`endif

// [src/dms_pkg.sv]
// types shared by both ends of the dds mode and tone select block
package dms_pkg;
   typedef enum logic [2:0] {
      DMS_SINGLE = 3'b000,
      DMS_FSK    = 3'b001,
      DMS_RAMPED = 3'b010,
      DMS_CHIRP  = 3'b011,
      DMS_BPSK   = 3'b100
   } dms_mode_t;
   typedef logic [5:0] dms_addr_t;
   typedef logic [7:0] dms_byte_t;
endpackage

// [src/dms_if.sv]
// parallel programming port and keying pin between host and synthesizer
`timescale 1ns/100ps
interface dms_if;
   logic             prog_wr;        // one-cycle byte write strobe
   dms_pkg::dms_addr_t prog_addr;
   dms_pkg::dms_byte_t prog_data;
   logic             port_parallel;  // high selects parallel port
   logic             master_reset;   // active-high initialisation
   logic             keying_select_pin;
   modport device (
      input prog_wr,
      input prog_addr,
      input prog_data,
      input port_parallel,
      input master_reset,
      input keying_select_pin
   );
   modport host (
      output prog_wr,
      output prog_addr,
      output prog_data,
      output port_parallel,
      output master_reset,
      output keying_select_pin
   );
endinterface

// [src/dms_device.sv]
// synthesizer end: registers, mode decode, tone select and accumulator
`timescale 1ns/100ps
`include "dms_defines.svh"
// Notes on behaviour
// - mode from three bits at address 1f
// - initialisation leaves single-tone mode
// - single tone drives accumulator from first word
// - defaults give 0 Hz, zero phase
// - converters sit at midscale after reset
// - word equals fout times 2^48 over clock
// - output spans dc to half clock
// - frequency changes keep phase continuous
// - cosine and sine always 90 degrees apart
// - one phase offset shifts both outputs
// - single tone amplitude has 12-bit control
// - keying pin low selects first word
// - keying pin high selects second word
// - keyed switch has fixed pipeline latency
// - second word only in keying modes
// - phase offset unused in phase-keying mode
// - keying pin ignored in single tone
// - host may reprogram at any time
// - active-high reset loads inert defaults
// - port select high means parallel port
module dms_device
   import dms_pkg::*;
(
   input  wire logic                   clock,
   input  wire logic                   arst_n,
   dms_if.device                       link,
   input  wire logic [`DMS_DAC_W-1:0]  amplitude,
   output logic      [`DMS_DAC_W-1:0]  dac_cos_q,
   output logic      [`DMS_DAC_W-1:0]  dac_sin_q,
   output logic      [2:0]             mode_q,
   output logic      [`DMS_FTW_W-1:0]  active_ftw_q,
   output logic      [`DMS_FTW_W-1:0]  phase_acc_q
);
   import dms_pkg::*;

   logic [`DMS_FTW_W-1:0]   first_tuning_word_q;
   logic [`DMS_FTW_W-1:0]   second_tuning_word_q;
   logic [7:0]              ctrl_q;
   logic [`DMS_PHASE_W-1:0] phase_off_q;
   logic [`DMS_PIPE_DEPTH-1:0] key_pipe_q;
   logic                    wr_ok;
   logic                    key_d;
   logic [`DMS_FTW_W-1:0]   active_ftw_d;
   logic [`DMS_PHASE_W-1:0] ph;

   // ------------------------------------------------------------
   // register writes
   // ------------------------------------------------------------
   // byte index within a 48-bit word, msb byte at the lowest address
   function automatic logic [2:0] byte_idx(input dms_addr_t a,
                                           input dms_addr_t base);
      logic [5:0] d;
      d = a - base;
      byte_idx = 3'(5 - d);
   endfunction

   // writes are refused while the serial port is selected
   assign wr_ok = link.prog_wr & link.port_parallel;

   // tuning word registers, inert default zero
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         first_tuning_word_q <= `DMS_FTW_RST;
         second_tuning_word_q <= `DMS_FTW_RST;
      end
      else if (link.master_reset)
      begin
         first_tuning_word_q <= `DMS_FTW_RST;
         second_tuning_word_q <= `DMS_FTW_RST;
      end
      else if (wr_ok)
      begin
         if (link.prog_addr >= `DMS_ADDR_FIRST_TUNING_WORD_LO &&
             link.prog_addr <= `DMS_ADDR_FIRST_TUNING_WORD_HI)
            first_tuning_word_q[8*byte_idx(link.prog_addr, `DMS_ADDR_FIRST_TUNING_WORD_LO) +: 8]
               <= link.prog_data;
         if (link.prog_addr >= `DMS_ADDR_SECOND_TUNING_WORD_LO &&
             link.prog_addr <= `DMS_ADDR_SECOND_TUNING_WORD_HI)
            second_tuning_word_q[8*byte_idx(link.prog_addr, `DMS_ADDR_SECOND_TUNING_WORD_LO) +: 8]
               <= link.prog_data;
      end
   end

   // control register holding the mode field
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         ctrl_q <= `DMS_CTRL_RST;
      else if (link.master_reset)
         ctrl_q <= `DMS_CTRL_RST;
      else if (wr_ok && link.prog_addr == `DMS_ADDR_CTRL)
         ctrl_q <= link.prog_data;
   end

   // phase offset takes the two bytes at addresses 00 and 01, below the tuning words
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         phase_off_q <= '0;
      else if (link.master_reset)
         phase_off_q <= '0;
      else if (wr_ok && link.prog_addr == `DMS_ADDR_PHASE_HI)
         phase_off_q[13:8] <= link.prog_data[5:0];
      else if (wr_ok && link.prog_addr == `DMS_ADDR_PHASE_LO)
         phase_off_q[7:0] <= link.prog_data;
   end

   // ------------------------------------------------------------
   // tone selection
   // ------------------------------------------------------------
   // keying pin delayed by a fixed pipeline
   // not cleared by initialisation: the pin is a level, not a register
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         key_pipe_q <= '0;
      else
         key_pipe_q <= {key_pipe_q[`DMS_PIPE_DEPTH-2:0],
                        link.keying_select_pin};
   end

   // oldest pipeline stage steers the word choice
   assign key_d = key_pipe_q[`DMS_PIPE_DEPTH-1];

   // word choice per mode
   // chirp and phase keying stay on the first word
   always_comb
   begin
      unique case (dms_mode_t'(ctrl_q[`DMS_MODE_LSB +: 3]))
         DMS_FSK,
         DMS_RAMPED : active_ftw_d = key_d ? second_tuning_word_q : first_tuning_word_q;
         default    : active_ftw_d = first_tuning_word_q;
      endcase
   end

   // mode copy, in step with the selected word
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         mode_q <= DMS_SINGLE;
      else
         mode_q <= ctrl_q[`DMS_MODE_LSB +: 3];
   end

   // selected word, registered so the keyed path has fixed latency
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         active_ftw_q <= `DMS_FTW_RST;
      else
         active_ftw_q <= active_ftw_d;
   end

   // ------------------------------------------------------------
   // accumulator and outputs
   // ------------------------------------------------------------
   // accumulator only adds, cleared only by initialisation, so phase is continuous
   // the carry out of the top bit is dropped: phase wraps every turn
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         phase_acc_q <= '0;
      else if (link.master_reset)
         phase_acc_q <= '0;
      else
         phase_acc_q <= phase_acc_q + active_ftw_q;
   end

   // offset applied equally unless in phase-keying mode
   assign ph = phase_acc_q[`DMS_FTW_W-1 -: `DMS_PHASE_W]
             + ((mode_q == DMS_BPSK) ? '0 : phase_off_q);

   // coarse triangle wave, amplitude scaled; quarter cycle apart
   function automatic logic [`DMS_DAC_W-1:0] wave(
      input logic [`DMS_PHASE_W-1:0] p,
      input logic [`DMS_DAC_W-1:0]   amp);
      logic [`DMS_DAC_W-1:0] tri_v;
      logic [2*`DMS_DAC_W-1:0] prod;
      tri_v = p[`DMS_PHASE_W-1] ? ~p[`DMS_PHASE_W-2 -: `DMS_DAC_W]
                                : p[`DMS_PHASE_W-2 -: `DMS_DAC_W];
      // signed distance from midscale, scaled by amplitude over full scale
      prod = ({12'h0, tri_v} - {12'h0, `DMS_DAC_MID}) * {12'h0, amp};
      wave = `DMS_DAC_MID + prod[2*`DMS_DAC_W-1 -: `DMS_DAC_W];
   endfunction

   // outputs start at midscale, amplitude zero gives midscale
   // cosine leads sine by a quarter turn of the phase word
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         dac_cos_q <= `DMS_DAC_MID;
         dac_sin_q <= `DMS_DAC_MID;
      end
      else
      begin
         dac_cos_q <= wave(ph + `DMS_QUARTER, amplitude);
         dac_sin_q <= wave(ph, amplitude);
      end
   end
endmodule // dms_device

// [src/dms_host.sv]
// host end: byte writer for tuning words, mode and keying pin
`timescale 1ns/100ps
`include "dms_defines.svh"
module dms_host
   import dms_pkg::*;
(
   input  wire logic                  clock,
   input  wire logic                  arst_n,
   dms_if.host                        link,
   input  wire logic                  init_req,
   input  wire logic                  cmd_valid,
   input  wire dms_pkg::dms_addr_t    cmd_addr,
   input  wire dms_pkg::dms_byte_t    cmd_data,
   input  wire logic                  key_level,
   output logic                       busy_q
);
   import dms_pkg::*;

   logic       wr_q;
   dms_addr_t  addr_q;
   dms_byte_t  data_q;
   logic       rst_q;
   logic       key_q;

   // -------------------------------------------------------------
   // byte writes, one per command, at the port rate
   // -------------------------------------------------------------
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         wr_q   <= 1'b0;
         addr_q <= '0;
         data_q <= '0;
      end
      else
      begin
         wr_q <= cmd_valid & ~rst_q;
         if (cmd_valid)
         begin
            addr_q <= cmd_addr;
            data_q <= cmd_data;
         end
      end
   end

   // initialisation pulse held from reset; keying level registered
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rst_q <= 1'b1;
         key_q <= 1'b0;
         busy_q <= 1'b1;
      end
      else
      begin
         rst_q  <= init_req;
         key_q  <= key_level;
         busy_q <= init_req;
      end
   end

   assign link.prog_wr           = wr_q;
   assign link.prog_addr         = addr_q;
   assign link.prog_data         = data_q;
   assign link.master_reset      = rst_q;
   assign link.port_parallel     = 1'b1;
   assign link.keying_select_pin = key_q;
endmodule // dms_host

// [tb/dms_asserts.sv]
// concurrent checks on the link and the synthesizer outputs
`timescale 1ns/100ps
module dms_asserts (
   input wire logic               clock,
   input wire logic               arst_n,
   input wire logic               prog_wr,
   input wire dms_pkg::dms_addr_t prog_addr,
   input wire dms_pkg::dms_byte_t prog_data,
   input wire logic               port_parallel,
   input wire logic               master_reset,
   input wire logic               keying_select_pin,
   input wire logic [11:0]        amplitude,
   input wire logic [11:0]        dac_cos_q,
   input wire logic [11:0]        dac_sin_q,
   input wire logic [2:0]         mode_q,
   input wire logic [47:0]        active_ftw_q,
   input wire logic [47:0]        phase_acc_q
);
   import dms_pkg::*;
   logic [2:0] fld_q;
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   // mode bits of the byte on the bus, one cycle late
   always_ff @(posedge clock)
      fld_q <= prog_data[3:1];
   // an accepted control write
   sequence s_ctrl_wr;
      prog_wr && port_parallel && !master_reset && prog_addr == 6'h1f;
   endsequence
   a_mode_follow: assert property (
      s_ctrl_wr |=> ##1 mode_q == $past(fld_q))
      else $error("mode field not taken from control write");
   a_reset_single_mode: assert property (
      master_reset [*2] |=> mode_q == DMS_SINGLE)
      else $error("initialisation left a mode other than single tone");
   a_reset_zero_word: assert property (
      master_reset [*6] |-> active_ftw_q == 48'h0)
      else $error("tuning word not cleared by initialisation");
   a_acc_steps: assert property (
      $past(!master_reset) |->
         phase_acc_q == $past(phase_acc_q) + $past(active_ftw_q))
      else $error("accumulator step differs from active word");
   a_zero_amp_mid: assert property (
      (amplitude == 12'h0) [*8] |->
         dac_cos_q == 12'h800 && dac_sin_q == 12'h800)
      else $error("converters off midscale at zero amplitude");
   a_single_ignores_pin: assert property (
      (mode_q == DMS_SINGLE && !prog_wr && !master_reset) [*6] |->
         $stable(active_ftw_q))
      else $error("word moved in single tone without a write");
   a_fsk_hold_word: assert property (
      (mode_q == DMS_FSK && !prog_wr && !master_reset &&
         $stable(keying_select_pin)) [*6] |-> $stable(active_ftw_q))
      else $error("keyed word moved with a steady pin");
   a_port_select: assert property (
      !master_reset |-> port_parallel)
      else $error("host left the parallel port deselected");
endmodule // dms_asserts

// [tb/dms_mode_and_tone_select_tb.sv]
// self-checking bench joining host and synthesizer ends
`timescale 1ns/100ps
module dms_mode_and_tone_select_tb;
   import dms_pkg::*;
   typedef struct {dms_byte_t ctrl; logic [2:0] mode;} dms_row_t;
   logic        clock        = 1'b0;
   logic        arst_n       = 1'b0;
   logic        init_req     = 1'b1;
   logic        cmd_valid    = 1'b0;
   dms_addr_t   cmd_addr     = 6'h00;
   dms_byte_t   cmd_data     = 8'h00;
   logic        key_level    = 1'b0;
   logic [11:0] amplitude    = 12'h000;
   logic [11:0] dac_cos_q, dac_sin_q;
   logic [2:0]  mode_q;
   logic [47:0] active_ftw_q, phase_acc_q, w1, w2, a0, c0, s0;
   logic        busy_q;
   int          miscompares  = 0;
   int          total_checks = 0;
   dms_row_t    rows [6]     = '{'{8'h00, 3'h0}, '{8'h02, 3'h1},
      '{8'h04, 3'h2}, '{8'h06, 3'h3}, '{8'h08, 3'h4}, '{8'hf1, 3'h0}};
   dms_if link ();
   dms_host i_dms_host (.clock(clock), .arst_n(arst_n), .link(link.host),
      .init_req(init_req), .cmd_valid(cmd_valid), .cmd_addr(cmd_addr),
      .cmd_data(cmd_data), .key_level(key_level), .busy_q(busy_q));
   dms_device i_dms_device (.clock(clock), .arst_n(arst_n),
      .link(link.device), .amplitude(amplitude), .dac_cos_q(dac_cos_q),
      .dac_sin_q(dac_sin_q), .mode_q(mode_q),
      .active_ftw_q(active_ftw_q), .phase_acc_q(phase_acc_q));
   dms_asserts i_dms_asserts (.clock(clock), .arst_n(arst_n),
      .prog_wr(link.prog_wr), .prog_addr(link.prog_addr),
      .prog_data(link.prog_data), .port_parallel(link.port_parallel),
      .master_reset(link.master_reset),
      .keying_select_pin(link.keying_select_pin), .amplitude(amplitude),
      .dac_cos_q(dac_cos_q), .dac_sin_q(dac_sin_q), .mode_q(mode_q),
      .active_ftw_q(active_ftw_q), .phase_acc_q(phase_acc_q));
   // 40 MHz clock
   always #12.5 clock = ~clock;
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic results;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input dms_addr_t a, input dms_byte_t d);
      @(posedge clock);
      cmd_valid <= 1'b1;
      cmd_addr <= a;
      cmd_data <= d;
      @(posedge clock);
      cmd_valid <= 1'b0;
   endtask
   // six bytes back to back, most significant first
   task automatic word(input dms_addr_t b, input logic [47:0] v);
      for (int i = 0; i < 6; i++)
      begin
         @(posedge clock);
         cmd_valid <= 1'b1;
         cmd_addr <= b + 6'(i);
         cmd_data <= v[47-8*i -: 8];
      end
      @(posedge clock);
      cmd_valid <= 1'b0;
   endtask
   task automatic settle;
      repeat (8) @(posedge clock);
      #1;
   endtask
   task automatic key(input logic k);
      @(posedge clock);
      key_level <= k;
   endtask
   // watchdog against a hang
   initial
   begin
      repeat (4000) @(posedge clock);
      miscompares++;
      results();
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      repeat (12) @(posedge clock);
      arst_n <= 1'b1;
      repeat (2) @(posedge clock);
      init_req <= 1'b0;
      settle();
      chk(48'(mode_q), 48'h0);
      chk(active_ftw_q, 48'h0);
      chk(phase_acc_q, 48'h0);
      chk(48'(dac_cos_q), 48'h800);
      chk(48'(dac_sin_q), 48'h800);
      chk(48'(busy_q), 48'h0);
      foreach (rows[i])
      begin
         wr(6'h1f, rows[i].ctrl);
         settle();
         chk(48'(mode_q), 48'(rows[i].mode));
      end
      // 1 MHz word rounded, and the half-rate word
      w1 = 48'(((64'h1 << 48) + 64'd20) / 64'd40);
      w2 = 48'h8000_0000_0000;
      word(6'h04, w1);
      word(6'h0a, w2);
      amplitude <= 12'h5a3;
      key(1'b1);
      settle();
      chk(active_ftw_q, w1);
      a0 = phase_acc_q;
      @(posedge clock);
      #1;
      chk(phase_acc_q, a0 + w1);
      wr(6'h1f, 8'h02);
      settle();
      chk(active_ftw_q, w2);
      key(1'b0);
      repeat (5) @(posedge clock);
      #1;
      chk(active_ftw_q, w2);
      a0 = phase_acc_q;
      @(posedge clock);
      #1;
      chk(active_ftw_q, w1);
      chk(phase_acc_q, a0 + w2);
      @(posedge clock);
      #1;
      chk(phase_acc_q, a0 + w2 + w1);
      key(1'b1);
      wr(6'h1f, 8'h06);
      settle();
      chk(active_ftw_q, w1);
      wr(6'h1f, 8'h08);
      wr(6'h3e, 8'h02);
      settle();
      chk(active_ftw_q, w1);
      chk(48'(mode_q), 48'h4);
      // ramped keying follows the pin, which is still high here
      wr(6'h1f, 8'h04);
      settle();
      chk(active_ftw_q, w2);
      @(posedge clock);
      amplitude <= 12'h000;
      init_req <= 1'b1;
      repeat (3) @(posedge clock);
      init_req <= 1'b0;
      #1;
      chk(48'(busy_q), 48'h1);
      chk(48'(link.master_reset), 48'h1);
      settle();
      chk(48'(mode_q), 48'h0);
      chk(active_ftw_q, 48'h0);
      chk(phase_acc_q, 48'h0);
      chk(48'(dac_cos_q), 48'h800);
      // frozen phase: a quarter-turn offset moves the sine onto the old cosine
      @(posedge clock);
      amplitude <= 12'hfff;
      settle();
      c0 = 48'(dac_cos_q);
      s0 = 48'(dac_sin_q);
      wr(6'h00, 8'h10);
      settle();
      chk(48'(dac_sin_q), c0);
      // phase keying ignores the offset, both bytes of it
      wr(6'h1f, 8'h08);
      wr(6'h01, 8'h2a);
      settle();
      chk(48'(dac_sin_q), s0);
      chk(48'(dac_cos_q), c0);
      results();
   end
endmodule // dms_mode_and_tone_select_tb
